// >>> src/boost_sup_pkg.sv
/*
 package of constants and carrier types for the boost supervisor.
 assumes a 25 MHz core clock; times are converted to clock counts here.
*/
package boost_sup_pkg;
   localparam int unsigned CLK_HZ            = 25000000;    // core clock rate
   localparam int unsigned UV_TIMEOUT_MS     = 110;         // undervoltage timeout
   localparam int unsigned DISCHARGE_MS      = 400;         // discharge phase
   // cycle counts, rounded down (shortest times)
   localparam int unsigned UV_TIMEOUT_CYC    = UV_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned DISCHARGE_CYC     = DISCHARGE_MS * (CLK_HZ / 1000);
   // sync clock: slowest legal external clock is 100 kHz
   localparam int unsigned SYNC_MIN_KHZ      = 100;
   localparam int unsigned SYNC_MAX_KHZ      = 2222;
   localparam int unsigned SYNC_LOSS_PERIODS = 4;           // periods without edge
   localparam int unsigned SYNC_LOSS_CYC     =
      SYNC_LOSS_PERIODS * (CLK_HZ / (SYNC_MIN_KHZ * 1000));
   // spread range codes and reset values
   localparam logic [1:0]  RANGE_3P3         = 2'h0;         // +-3.3 %
   localparam logic [1:0]  RANGE_4P3         = 2'h1;         // +-4.3 %
   localparam logic [1:0]  RANGE_5P3         = 2'h2;         // +-5.3 %
   localparam logic [1:0]  RANGE_7P2         = 2'h3;         // +-7.2 %
   localparam logic [1:0]  RANGE_RESET       = RANGE_5P3;
   localparam logic [1:0]  RATE_200          = 2'h0;         // 200 Hz
   localparam logic [1:0]  RATE_500          = 2'h1;         // 500 Hz
   localparam logic [1:0]  RATE_800          = 2'h2;         // 800 Hz
   localparam logic [1:0]  RATE_1200         = 2'h3;         // 1200 Hz
   localparam logic [1:0]  RATE_RESET        = RATE_200;
   // deviation in tenths of a percent and rate in hertz
   localparam logic [7:0]  DEV_3P3           = 8'h21;        // 33
   localparam logic [7:0]  DEV_4P3           = 8'h2B;        // 43
   localparam logic [7:0]  DEV_5P3           = 8'h35;        // 53
   localparam logic [7:0]  DEV_7P2           = 8'h48;        // 72
   localparam logic [10:0] HZ_200            = 11'h0C8;
   localparam logic [10:0] HZ_500            = 11'h1F4;
   localparam logic [10:0] HZ_800            = 11'h320;
   localparam logic [10:0] HZ_1200           = 11'h4B0;

   // comparator inputs from the power stage
   typedef struct packed {
      logic uv;          // output below undervoltage level
      logic ovp_low;     // feedback above low overvoltage level
      logic ovp_high;    // feedback above high overvoltage level
      logic dis_high;    // discharge pin above high overvoltage level
      logic light_load;  // light load detected
   } comp_t;

   // sticky status flags
   typedef struct packed {
      logic high_ovp_flag;
      logic low_ovp_flag;
      logic undervolt_timeout_flag;
   } status_t;

   // power stage controls
   typedef struct packed {
      logic switch_en;   // boost switch allowed
      logic sinks_en;    // led current sinks on
      logic fet_on;      // power-line fet on
      logic discharge;   // discharge pin sinking
      logic fault_rec;   // in fault recovery
      logic pfm_skip;    // skip this cycle
   } stage_t;

   // clock mode
   typedef struct packed {
      logic       ext_sync;   // running from external clock
      logic       spread_en;  // spreading on
      logic [7:0] dev_tenths; // deviation, tenths of a percent
      logic [10:0] mod_hz;    // modulation rate
   } clkmode_t;
endpackage : boost_sup_pkg

// >>> src/sync_detect.sv
/*
 detects an external clock on the sync pin and its loss.
 assumes the pin is already synchronous to clk_in.
*/
`timescale 1ns/1ps
module sync_detect
   import boost_sup_pkg::*;
#(
   parameter int unsigned LOSS_CYC = SYNC_LOSS_CYC
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   input  wire logic pin_in,
   output logic      clock_present_out,
   output logic      level_out
);
   logic [$clog2(LOSS_CYC+1)-1:0] idle_reg;   // cycles since last edge
   logic                          pin_d_reg;  // previous pin sample
   logic                          edge_seen;  // pin changed

   assign edge_seen = pin_in ^ pin_d_reg;

   // last level and edge counter
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_d_reg <= 1'b0;
         // start as silent, so a high pin after reset is no clock
         idle_reg  <= LOSS_CYC[$bits(idle_reg)-1:0];
      end else if (ce_in) begin
         pin_d_reg <= pin_in;
         if (edge_seen)
            idle_reg <= '0;
         else if (idle_reg != LOSS_CYC[$bits(idle_reg)-1:0])
            idle_reg <= idle_reg + 1'b1;
      end
   end

   // present once two edges close together, lost after long silence
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clock_present_out <= 1'b0;
         level_out         <= 1'b0;
      end else if (ce_in) begin
         level_out <= pin_in;
         if (edge_seen && idle_reg != LOSS_CYC[$bits(idle_reg)-1:0])
            clock_present_out <= 1'b1;
         else if (!edge_seen && idle_reg == LOSS_CYC[$bits(idle_reg)-1:0])
            clock_present_out <= 1'b0;
      end
   end
endmodule : sync_detect

// >>> src/boost_supervisor.sv
/*
 digital supervision of a backlight boost controller: faults, clock mode,
 spread coding and discharge sequencing.
 assumes comparator and pin inputs synchronous to clk_in at 25 MHz.
// Overview of operation
// - undervoltage lasting 110 ms enters fault recovery
// - high overvoltage enters fault recovery, sets flag
// - static sync level low/high turns spreading off/on
// - external sync clock adopted with spreading off
// - lost sync clock falls back to resistor frequency
// - range field maps to deviation, reset 10
// - rate field maps to modulation, reset 00
// - enable fall stops switching, sinks, fet; discharges
// - discharge lasts 400 ms then shutdown
// - discharge pin overvoltage enters fault recovery
// - light load skips switching cycles
// - low overvoltage stops switch, sets flag
*/
`timescale 1ns/1ps
module boost_supervisor
   import boost_sup_pkg::*;
#(
   parameter int unsigned UV_CYC  = UV_TIMEOUT_CYC,   // shorten for simulation
   parameter int unsigned DIS_CYC = DISCHARGE_CYC,    // shorten for simulation
   parameter int unsigned LOSS_CYC = SYNC_LOSS_CYC    // shorten for simulation
) (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       enable_in,
   input  wire logic       boost_sync_pin_in,
   input  wire comp_t      comp_in,
   input  wire logic [1:0] spread_range_in,
   input  wire logic [1:0] spread_rate_sel_in,
   input  wire logic       cfg_write_in,
   input  wire status_t    status_clear_in,
   input  wire logic       recovery_done_in,
   output status_t         status_out,
   output stage_t          stage_out,
   output clkmode_t        clkmode_out,
   output logic            shutdown_out
);
   typedef enum logic [2:0] {
      ST_OFF,
      ST_RUN,
      ST_DISCHARGE,
      ST_FAULT
   } state_t;

   state_t      state_reg;       // main sequencer
   state_t      state_next;
   logic        en_d_reg;        // previous enable
   logic [31:0] uv_cnt_reg;      // undervoltage timer
   logic [31:0] dis_cnt_reg;     // discharge timer
   logic [1:0]  range_reg;       // spread range field
   logic [1:0]  rate_reg;        // spread rate field
   logic        sync_present;    // external clock seen
   logic        sync_level;      // last static level
   logic        uv_expire;       // undervoltage timeout
   logic        hi_fault;        // any high overvoltage source
   logic        en_fall;         // enable falling edge

   assign uv_expire = (state_reg == ST_RUN) && comp_in.uv
                      && (uv_cnt_reg == UV_CYC - 1);
   assign hi_fault  = comp_in.ovp_high || comp_in.dis_high;
   assign en_fall   = en_d_reg && !enable_in;

   // sync clock detector
   sync_detect #(
      .LOSS_CYC (LOSS_CYC)
   ) u_sync (
      .clk_in            (clk_in),
      .rst_n_in          (rst_n_in),
      .ce_in             (ce_in),
      .pin_in            (boost_sync_pin_in),
      .clock_present_out (sync_present),
      .level_out         (sync_level)
   );

   // enable edge history
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         en_d_reg <= 1'b0;
      else if (ce_in)
         en_d_reg <= enable_in;
   end

   // undervoltage timer, cleared once output recovers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         uv_cnt_reg <= '0;
      else if (ce_in) begin
         if (state_reg == ST_RUN && comp_in.uv)
            uv_cnt_reg <= uv_cnt_reg + 32'h1;
         else
            uv_cnt_reg <= '0;
      end
   end

   // discharge timer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         dis_cnt_reg <= '0;
      else if (ce_in) begin
         if (state_reg == ST_DISCHARGE)
            dis_cnt_reg <= dis_cnt_reg + 32'h1;
         else
            dis_cnt_reg <= '0;
      end
   end

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_OFF: begin
            if (enable_in)
               state_next = ST_RUN;
         end
         ST_RUN: begin
            if (en_fall)
               state_next = ST_DISCHARGE;
            else if (hi_fault || uv_expire)
               state_next = ST_FAULT;
         end
         ST_DISCHARGE: begin
            if (comp_in.dis_high)
               state_next = ST_FAULT;
            else if (dis_cnt_reg == DIS_CYC - 1)
               state_next = ST_OFF;
         end
         ST_FAULT: begin
            if (recovery_done_in)
               state_next = enable_in ? ST_RUN : ST_OFF;
         end
         default: state_next = ST_OFF;
      endcase
   end

   // sequencer register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         state_reg <= ST_OFF;
      else if (ce_in)
         state_reg <= state_next;
   end

   // sticky flags; a set wins over a clear in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         status_out <= '0;
      else if (ce_in) begin
         status_out.high_ovp_flag <= (status_out.high_ovp_flag
            && !status_clear_in.high_ovp_flag)
            || (state_reg == ST_RUN && hi_fault)
            || (state_reg == ST_DISCHARGE && comp_in.dis_high);
         status_out.low_ovp_flag <= (status_out.low_ovp_flag
            && !status_clear_in.low_ovp_flag)
            || (state_reg == ST_RUN && comp_in.ovp_low);
         status_out.undervolt_timeout_flag <= (status_out.undervolt_timeout_flag
            && !status_clear_in.undervolt_timeout_flag)
            || uv_expire;
      end
   end

   // power stage controls
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage_out    <= '0;
         shutdown_out <= 1'b1;
      end else if (ce_in) begin
         stage_out.sinks_en  <= (state_next == ST_RUN);
         stage_out.fet_on    <= (state_next == ST_RUN);
         stage_out.switch_en <= (state_next == ST_RUN)
                                && !comp_in.ovp_low;
         stage_out.discharge <= (state_next == ST_DISCHARGE);
         stage_out.fault_rec <= (state_next == ST_FAULT);
         stage_out.pfm_skip  <= (state_next == ST_RUN)
                                && comp_in.light_load;
         shutdown_out        <= (state_next == ST_OFF);
      end
   end

   // spread fields, loaded on write
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         range_reg <= RANGE_RESET;
         rate_reg  <= RATE_RESET;
      end else if (ce_in && cfg_write_in) begin
         range_reg <= spread_range_in;
         rate_reg  <= spread_rate_sel_in;
      end
   end

   // clock mode and spread coding
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         clkmode_out <= '0;
      else if (ce_in) begin
         clkmode_out.ext_sync  <= sync_present;
         clkmode_out.spread_en <= !sync_present && sync_level;
         unique case (range_reg)
            RANGE_3P3: clkmode_out.dev_tenths <= DEV_3P3;
            RANGE_4P3: clkmode_out.dev_tenths <= DEV_4P3;
            RANGE_5P3: clkmode_out.dev_tenths <= DEV_5P3;
            RANGE_7P2: clkmode_out.dev_tenths <= DEV_7P2;
         endcase
         unique case (rate_reg)
            RATE_200:  clkmode_out.mod_hz <= HZ_200;
            RATE_500:  clkmode_out.mod_hz <= HZ_500;
            RATE_800:  clkmode_out.mod_hz <= HZ_800;
            RATE_1200: clkmode_out.mod_hz <= HZ_1200;
         endcase
      end
   end

   // undervoltage timeout faults at the next edge unless enable fell first
   a_uv_timeout_fault: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && uv_expire && !en_fall
      |=> status_out.undervolt_timeout_flag && state_reg == ST_FAULT)
      else $error("undervoltage timeout did not fault");
   // a recovered output restarts the timer
   a_uv_restart: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && !comp_in.uv |=> uv_cnt_reg == 32'h0)
      else $error("undervoltage timer kept running");
   // feedback high overvoltage
   a_high_ovp_fault: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && state_reg == ST_RUN && comp_in.ovp_high && !en_fall
      |=> state_reg == ST_FAULT && status_out.high_ovp_flag)
      else $error("high overvoltage did not fault");
   // fault recovery drops the power stage
   a_fault_outputs: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && state_next == ST_FAULT
      |=> stage_out.fault_rec && !stage_out.switch_en && !stage_out.fet_on)
      else $error("power stage on in fault recovery");
   // static level drives spreading
   a_spread_static: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && !sync_present |=> clkmode_out.spread_en == $past(sync_level))
      else $error("spread does not follow static level");
   // external clock adopted with spreading off
   a_sync_adopt: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && sync_present |=> clkmode_out.ext_sync && !clkmode_out.spread_en)
      else $error("external clock not adopted");
   a_sync_no_spread: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      clkmode_out.ext_sync |-> !clkmode_out.spread_en)
      else $error("spread on in sync mode");
   // clock loss returns to the resistor frequency and the final level
   sequence s_sync_lost;
      ce_in && $fell(sync_present);
   endsequence
   a_sync_fallback: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_sync_lost |=> !clkmode_out.ext_sync && clkmode_out.spread_en == $past(sync_level))
      else $error("no fallback after clock loss");
   // spread field coding
   a_range_code: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && range_reg == RANGE_5P3 |=> clkmode_out.dev_tenths == DEV_5P3)
      else $error("range coding wrong");
   a_rate_code: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && rate_reg == RATE_1200 |=> clkmode_out.mod_hz == HZ_1200)
      else $error("rate coding wrong");
   // enable fall starts discharge with the stage off
   sequence s_fall;
      ce_in && state_reg == ST_RUN && en_fall;
   endsequence
   a_enable_fall: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_fall |=> stage_out.discharge && !stage_out.fet_on
                 && !stage_out.sinks_en && !stage_out.switch_en)
      else $error("enable fall did not start discharge");
   // discharge ends in shutdown and never overruns its timer
   a_discharge_end: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && state_reg == ST_DISCHARGE && dis_cnt_reg == DIS_CYC - 1
      && !comp_in.dis_high |=> state_reg == ST_OFF && shutdown_out)
      else $error("discharge did not end in shutdown");
   a_dis_timer_bound: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      state_reg == ST_DISCHARGE |-> dis_cnt_reg < DIS_CYC)
      else $error("discharge timer overran");
   a_dis_pin_fault: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && state_reg == ST_DISCHARGE && comp_in.dis_high
      |=> state_reg == ST_FAULT && status_out.high_ovp_flag)
      else $error("discharge pin overvoltage missed");
   a_light_skip: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && state_next == ST_RUN && comp_in.light_load |=> stage_out.pfm_skip)
      else $error("light load did not skip");
   // low overvoltage pauses only the switch
   a_low_ovp_stop: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && comp_in.ovp_low |=> !stage_out.switch_en)
      else $error("switch on during low overvoltage");
   a_low_ovp_sinks: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && state_reg == ST_RUN && comp_in.ovp_low && enable_in && !hi_fault
      && !uv_expire |=> stage_out.sinks_en && status_out.low_ovp_flag)
      else $error("low overvoltage stopped the sinks");
   // flags hold until cleared, and a low clock enable holds all state
   a_flag_sticky: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && status_out.low_ovp_flag && !status_clear_in.low_ovp_flag
      |=> status_out.low_ovp_flag)
      else $error("flag dropped without clear");
   a_ce_freeze: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !ce_in |=> $stable(status_out) && $stable(state_reg) && $stable(clkmode_out))
      else $error("state moved with clock enable low");
endmodule : boost_supervisor

// >>> tb/power_stage_model.sv
/*
 partner model: comparator levels and sync pin of the external power stage.
 assumes bench commands sampled on clk_in; comparators lag them by one cycle.
*/
`timescale 1ns/1ps
module power_stage_model
   import boost_sup_pkg::*;
#(
   parameter int unsigned HALF_CYC = 6    // half period of the sync clock
) (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire comp_t      cmd_in,
   input  wire logic [1:0] sync_mode_in,
   output comp_t           comp_out,
   output logic            sync_pin_out
);
   int unsigned cnt_reg;                  // spacing of sync toggles
   // comparators settle one cycle after the bench asks for a condition
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         comp_out <= '0;
      end else begin
         comp_out <= cmd_in;
      end
   end
   // mode 0 or 1 holds that level, mode 2 runs a clock of 25 MHz / 12
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg      <= 0;
         sync_pin_out <= 1'b0;
      end else if (sync_mode_in == 2'h2) begin
         cnt_reg <= (cnt_reg == HALF_CYC - 1) ? 0 : cnt_reg + 1;
         if (cnt_reg == HALF_CYC - 1) begin
            sync_pin_out <= ~sync_pin_out;
         end
      end else begin
         cnt_reg      <= 0;
         sync_pin_out <= sync_mode_in[0];
      end
   end
endmodule : power_stage_model

// >>> tb/boost_supervisor_tb_top.sv
/*
 self-checking bench of the boost supervisor with a queue of expected notes.
 assumes power_stage_model drives the comparators and the sync pin.
*/
`timescale 1ns/1ps
module boost_supervisor_tb_top
   import boost_sup_pkg::*;
;
   localparam int unsigned UV_T   = 20;   // shortened timeout
   localparam int unsigned DIS_T  = 30;   // shortened discharge
   localparam int unsigned LOSS_T = 16;   // shortened sync loss
   typedef struct packed {
      logic [1:0]  kind;                  // 0 status 1 stage 2 clkmode 3 shutdown
      logic [20:0] mask;
      logic [20:0] exp;
   } note_t;
   logic        clk_in             = 1'b0;
   logic        rst_n_in           = 1'b0;
   logic        ce_in              = 1'b1;
   logic        enable_in          = 1'b0;
   logic        cfg_write_in       = 1'b0;
   logic        recovery_done_in   = 1'b0;
   logic [1:0]  spread_range_in    = 2'h0;
   logic [1:0]  spread_rate_sel_in = 2'h0;
   logic [1:0]  sync_mode          = 2'h0;
   status_t     status_clear_in    = '0;
   comp_t       cmd                = '0;
   comp_t       comp_in;
   logic        sync_pin;
   status_t     status_out;
   stage_t      stage_out;
   clkmode_t    clkmode_out;
   logic        shutdown_out;
   note_t       notes[$];
   int          n_mismatch         = 0;
   int          samples_checked    = 0;
   event        sample_ev;
   logic [7:0]  dev_tab [4]        = '{DEV_3P3, DEV_4P3, DEV_5P3, DEV_7P2};
   logic [10:0] hz_tab [4]         = '{HZ_200, HZ_500, HZ_800, HZ_1200};
   logic [1:0]  mode_tab [5]       = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h1};
   logic [1:0]  sx_tab [5]         = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h1};

   always #20 clk_in = ~clk_in;           // 25 MHz

   boost_supervisor #(.UV_CYC(UV_T), .DIS_CYC(DIS_T), .LOSS_CYC(LOSS_T)) dut_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .enable_in(enable_in),
      .boost_sync_pin_in(sync_pin), .comp_in(comp_in),
      .spread_range_in(spread_range_in), .spread_rate_sel_in(spread_rate_sel_in),
      .cfg_write_in(cfg_write_in), .status_clear_in(status_clear_in),
      .recovery_done_in(recovery_done_in), .status_out(status_out),
      .stage_out(stage_out), .clkmode_out(clkmode_out), .shutdown_out(shutdown_out));

   power_stage_model model_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd), .sync_mode_in(sync_mode),
      .comp_out(comp_in), .sync_pin_out(sync_pin));

   // wait edges, then let their updates land
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cyc
   // note an expected output and wake the watcher
   task automatic look(input logic [1:0] k, input logic [20:0] m, input logic [20:0] e);
      notes.push_back('{k, m, e});
      -> sample_ev;
      #0;
   endtask : look
   task automatic compare(input logic [20:0] got, input logic [20:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : compare
   // clear every flag and leave fault recovery
   task automatic recover;
      @(posedge clk_in);
      status_clear_in  <= 3'h7;
      recovery_done_in <= 1'b1;
      @(posedge clk_in);
      status_clear_in  <= '0;
      recovery_done_in <= 1'b0;
      cyc(2);
   endtask : recover
   task automatic tally_and_finish;
      -> sample_ev;
      #1;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // watcher: takes the oldest note and compares the matching output
   initial begin : watcher
      note_t       nt;
      logic [20:0] got;
      forever begin
         @(sample_ev);
         while (notes.size() > 0) begin
            nt = notes.pop_front();
            case (nt.kind)
               2'h0:    got = 21'(status_out);
               2'h1:    got = 21'(stage_out);
               2'h2:    got = clkmode_out;
               default: got = 21'(shutdown_out);
            endcase
            compare(got & nt.mask, nt.exp);
         end
      end
   end

   // watchdog far beyond the expected run of about 450 cycles
   initial begin : watchdog
      #800000;
      n_mismatch++;
      tally_and_finish();
   end

   initial begin : main
      int r;
      void'($urandom(11205));
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      cyc(2);
      look(2'h2, 21'h07FFFF, {2'h0, DEV_5P3, HZ_200});
      look(2'h3, 21'h1, 21'h1);
      // every range code, every rate code from a random start
      r = $urandom % 4;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         spread_range_in    <= 2'(i);
         spread_rate_sel_in <= 2'((i + r) % 4);
         cfg_write_in       <= 1'b1;
         @(posedge clk_in);
         cfg_write_in <= 1'b0;
         cyc(2);
         look(2'h2, 21'h07FFFF, {2'h0, dev_tab[i], hz_tab[(i + r) % 4]});
      end
      // a write while the clock enable is low is refused
      @(posedge clk_in);
      ce_in           <= 1'b0;
      spread_range_in <= RANGE_3P3;
      cfg_write_in    <= 1'b1;
      @(posedge clk_in);
      ce_in        <= 1'b1;
      cfg_write_in <= 1'b0;
      cyc(2);
      look(2'h2, 21'h07FFFF, {2'h0, DEV_7P2, hz_tab[(3 + r) % 4]});
      @(posedge clk_in) enable_in <= 1'b1;
      cyc(3);
      look(2'h1, 21'h3C, 21'h38);
      // high overvoltage on feedback, then on the discharge pin
      for (int j = 0; j < 2; j++) begin
         @(posedge clk_in) cmd <= (j == 0) ? comp_t'(5'h04) : comp_t'(5'h02);
         cyc(3);
         look(2'h1, 21'h02, 21'h02);
         look(2'h0, 21'h4, 21'h4);
         @(posedge clk_in) cmd <= '0;
         cyc(4);
         look(2'h0, 21'h4, 21'h4);
         recover();
         look(2'h0, 21'h4, 21'h0);
         look(2'h1, 21'h3E, 21'h38);
      end
      // low overvoltage pauses only the switch
      @(posedge clk_in) cmd <= comp_t'(5'h08);
      cyc(3);
      look(2'h1, 21'h32, 21'h10);
      look(2'h0, 21'h2, 21'h2);
      @(posedge clk_in) cmd <= '0;
      cyc(3);
      look(2'h1, 21'h20, 21'h20);
      look(2'h0, 21'h2, 21'h2);
      recover();
      // a short dip recovers, a long one times out
      @(posedge clk_in) cmd <= comp_t'(5'h10);
      cyc(UV_T / 2);
      @(posedge clk_in) cmd <= '0;
      cyc(UV_T + 4);
      look(2'h0, 21'h1, 21'h0);
      @(posedge clk_in) cmd <= comp_t'(5'h10);
      cyc(UV_T - 1);
      look(2'h0, 21'h1, 21'h0);
      cyc(4);
      look(2'h0, 21'h1, 21'h1);
      look(2'h1, 21'h2, 21'h2);
      @(posedge clk_in) cmd <= '0;
      recover();
      // light load skips cycles
      @(posedge clk_in) cmd <= comp_t'(5'h01);
      for (int k = 0; k < 8 && stage_out.pfm_skip !== 1'b1; k++) cyc(1);
      look(2'h1, 21'h1, 21'h1);
      @(posedge clk_in) cmd <= '0;
      cyc(3);
      look(2'h1, 21'h1, 21'h0);
      // static levels, external clock, and clock lost at each level
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_in) sync_mode <= mode_tab[i];
         if (i > 0 && mode_tab[i - 1] == 2'h2) begin
            cyc(LOSS_T / 2);
            look(2'h2, 21'h100000, 21'h100000);
         end
         cyc(48);
         look(2'h2, 21'h180000, {sx_tab[i], 19'h0});
      end
      // enable fall: discharge, then shutdown
      @(posedge clk_in) enable_in <= 1'b0;
      cyc(3);
      look(2'h1, 21'h3C, 21'h04);
      look(2'h3, 21'h1, 21'h0);
      cyc(DIS_T - 6);
      look(2'h3, 21'h1, 21'h0);
      cyc(8);
      look(2'h3, 21'h1, 21'h1);
      look(2'h1, 21'h4, 21'h0);
      // discharge pin overvoltage while discharging
      @(posedge clk_in) enable_in <= 1'b1;
      cyc(3);
      @(posedge clk_in) enable_in <= 1'b0;
      cyc(3);
      @(posedge clk_in) cmd <= comp_t'(5'h02);
      cyc(3);
      look(2'h1, 21'h06, 21'h02);
      look(2'h0, 21'h4, 21'h4);
      @(posedge clk_in) cmd <= '0;
      tally_and_finish();
   end
endmodule : boost_supervisor_tb_top
